/* File: inc/lsc_pkg.sv */
/*
 Constants, register map and carrier structs for the light sensor conversion timing block.
 Assumes a host-side bus front end that delivers decoded register writes, reads and sync strobes.
*/
package lsc_pkg;
	// Register map
	localparam logic [7:0] ADDR_COMMAND = 8'h00;
	localparam logic [7:0] ADDR_RESULT_LOW = 8'h01;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'h02;
	localparam int SYNC_ADDR_BIT = 7;
	localparam logic [6:0] TARGET_ADDRESS = 7'h44;
	// Command register fields
	localparam int CMD_ENABLE_BIT = 7;
	localparam int CMD_CONTINUOUS_BIT = 6;
	localparam int CMD_TIMING_MODE_BIT = 4;
	localparam int CMD_RES_LSB = 2;
	// Reset values
	localparam logic [7:0] COMMAND_RESET = 8'h00;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	// Integration lengths in oscillator cycles, minus one
	localparam logic [15:0] CYCLES_16BIT = 16'hFFFF;
	localparam logic [15:0] CYCLES_12BIT = 16'h0FFF;
	localparam logic [15:0] CYCLES_8BIT = 16'h00FF;
	localparam logic [15:0] CYCLES_4BIT = 16'h000F;
	// Timing mode decode of command bits 4:2
	localparam logic [2:0] MODE_EXT_ADC = 3'h4;
	localparam logic [2:0] MODE_EXT_TIMER = 3'h5;

	typedef enum logic [1:0] {LSC_IDLE, LSC_WAIT_SYNC, LSC_INTEGRATE} lsc_phase_e;

	// Decoded register access from the serial front end
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lsc_access_s;

	// Whole state of the block
	typedef struct packed {
		logic [7:0] command;
		lsc_phase_e phase;
		logic [15:0] cycle_count;
		logic [15:0] adc_acc;
		logic [15:0] adc_result;
		logic [15:0] timer_result;
		logic [15:0] shown;
		logic [7:0] rdata;
		logic rvalid;
		logic done;
		logic overflow;
	} lsc_state_s;
endpackage : lsc_pkg

/* File: verilog/lsc_conversion.sv */
/*
 Conversion timing and result readout of an ambient light sensor.
 Holds the command register, the integration cycle counter, the
 converter pulse accumulator and the published 16-bit result word.
 Internal timing closes a window after a fixed power-of-two tick count;
 external timing opens and closes windows on sync writes.
 Resolution bits pick 16, 12, 8 or 4 bit internal windows.
 Both result bytes update in one cycle from one word.
 Writes to the result addresses leave the result word untouched.
 Reads of unmapped addresses return zero.
 A command write aborts any running integration and restarts it if the new command sets enable.
 Sync writes are ignored while internal timing is selected.
 A sync in the cycle right after a command write is lost,
 so the host leaves one idle cycle there.
 The overflow output flags a window that wrapped the counter;
 it clears when that window closes or the next one starts, not on a command write.
 Assumes: a serial front end decodes transfers addressed to the target address into
 one-cycle access strobes; osc_tick marks each internal oscillator cycle; photo_pulse
 marks each charge quantum counted by the integrating converter.
 Assumes all inputs are synchronous to clk and reset is held for one edge at least.
 Assumes the host spaces sync writes closely enough to avoid a counter wrap.
*/
`timescale 1ns/1ps
module lsc_conversion (
	input wire logic clk,
	input wire logic reset,
	input wire logic [6:0] bus_target,
	input wire lsc_pkg::lsc_access_s access,
	input wire logic osc_tick,
	input wire logic photo_pulse,
	output logic [7:0] read_data,
	output logic read_valid,
	output logic [7:0] command_out,
	output logic conversion_done,
	output logic powered_up,
	output logic counter_overflow
);
	// Whole block state, current and next
	lsc_pkg::lsc_state_s s_q;
	lsc_pkg::lsc_state_s s_d;
	// Decode and datapath helpers
	logic addressed;
	logic is_sync;
	logic cmd_write;
	logic enabled;
	logic external;
	logic [2:0] mode;
	logic [15:0] last_cycle;
	logic finish;
	logic [15:0] adc_next;
	logic [15:0] new_shown;

	// Access decode
	assign addressed = (bus_target == lsc_pkg::TARGET_ADDRESS);
	assign is_sync = addressed && access.wr && access.addr[lsc_pkg::SYNC_ADDR_BIT];
	assign cmd_write = addressed && access.wr && (access.addr == lsc_pkg::ADDR_COMMAND);
	assign enabled = s_q.command[lsc_pkg::CMD_ENABLE_BIT];
	assign mode = s_q.command[lsc_pkg::CMD_TIMING_MODE_BIT:lsc_pkg::CMD_RES_LSB];
	assign external = s_q.command[lsc_pkg::CMD_TIMING_MODE_BIT];

	// Internal integration length per resolution bits
	always_comb
	begin
		unique case (mode[1:0])
			2'b00: last_cycle = lsc_pkg::CYCLES_16BIT;
			2'b01: last_cycle = lsc_pkg::CYCLES_12BIT;
			2'b10: last_cycle = lsc_pkg::CYCLES_8BIT;
			2'b11: last_cycle = lsc_pkg::CYCLES_4BIT;
		endcase
	end

	// Converter accumulator with this cycle's pulse included
	assign adc_next = s_q.adc_acc + {15'h0000, photo_pulse};

	// End of integration: fixed count internally, sync externally
	always_comb
	begin
		finish = 1'b0;
		// Syncs only close a window in external mode
		if (s_q.phase == lsc_pkg::LSC_INTEGRATE)
		begin
			if (external)
				finish = is_sync;
			else
				finish = osc_tick && (s_q.cycle_count == last_cycle);
		end
	end

	// Next state
	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.rvalid = 1'b0;
		new_shown = s_q.shown;
		// Command write takes effect at once
		if (cmd_write)
		begin
			s_d.command = access.wdata;
			// Integration restarts under the new settings
			s_d.phase = lsc_pkg::LSC_IDLE;
		end

		unique case (s_q.phase)
			lsc_pkg::LSC_IDLE:
			begin
				// Clear counters and pick sync wait or integration by timing mode
				if (enabled && !cmd_write)
				begin
					s_d.cycle_count = 16'h0000;
					s_d.adc_acc = 16'h0000;
					s_d.overflow = 1'b0;
					s_d.phase = external ? lsc_pkg::LSC_WAIT_SYNC : lsc_pkg::LSC_INTEGRATE;
				end
			end
			lsc_pkg::LSC_WAIT_SYNC:
			begin
				// External mode opens on the first sync
				if (is_sync && !cmd_write)
					s_d.phase = lsc_pkg::LSC_INTEGRATE;
			end
			lsc_pkg::LSC_INTEGRATE:
			begin
				if (!cmd_write)
				begin
					// Oscillator counting is the same in both modes
					if (osc_tick)
					begin
						s_d.cycle_count = s_q.cycle_count + 16'h0001;
						if (s_q.cycle_count == 16'hFFFF)
							s_d.overflow = 1'b1;
					end
					s_d.adc_acc = adc_next;
					// Close the window and publish one word
					if (finish)
					begin
						s_d.adc_result = adc_next;
						s_d.timer_result = s_q.cycle_count + {15'h0000, osc_tick};
						s_d.done = 1'b1;
						new_shown = (mode == lsc_pkg::MODE_EXT_TIMER) ?
							s_d.timer_result : adc_next;
						s_d.cycle_count = 16'h0000;
						s_d.adc_acc = 16'h0000;
						s_d.overflow = 1'b0;
						// One-time mode drops enable and idles
						if (!s_q.command[lsc_pkg::CMD_CONTINUOUS_BIT])
						begin
							s_d.command[lsc_pkg::CMD_ENABLE_BIT] = 1'b0;
							s_d.phase = lsc_pkg::LSC_IDLE;
						end
					end
				end
			end
		endcase

		// Command picks the shown word; external codes switch even mid-window
		if (cmd_write && (s_q.phase != lsc_pkg::LSC_INTEGRATE ||
			access.wdata[lsc_pkg::CMD_TIMING_MODE_BIT]))
			new_shown = (access.wdata[lsc_pkg::CMD_TIMING_MODE_BIT:lsc_pkg::CMD_RES_LSB] ==
				lsc_pkg::MODE_EXT_TIMER) ? s_q.timer_result : s_q.adc_result;
		s_d.shown = new_shown;

		// Register read; result bytes ignore writes
		if (addressed && access.rd)
		begin
			s_d.rvalid = 1'b1;
			unique case (access.addr)
				lsc_pkg::ADDR_COMMAND: s_d.rdata = s_q.command;
				lsc_pkg::ADDR_RESULT_LOW: s_d.rdata = s_q.shown[7:0];
				lsc_pkg::ADDR_RESULT_HIGH: s_d.rdata = s_q.shown[15:8];
				default: s_d.rdata = 8'h00;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			// Counters, flags and results all start cleared
			s_q <= '0;
			s_q.command <= lsc_pkg::COMMAND_RESET;
			s_q.phase <= lsc_pkg::LSC_IDLE;
			s_q.shown <= lsc_pkg::RESULT_RESET;
			s_q.adc_result <= lsc_pkg::RESULT_RESET;
			s_q.timer_result <= lsc_pkg::RESULT_RESET;
		end
		else
			s_q <= s_d;
	end

	// Read port straight from state flops
	assign read_data = s_q.rdata;
	assign read_valid = s_q.rvalid;

	// Status outputs straight from state flops
	assign command_out = s_q.command;
	assign conversion_done = s_q.done;
	assign powered_up = s_q.command[lsc_pkg::CMD_ENABLE_BIT];
	assign counter_overflow = s_q.overflow;
endmodule : lsc_conversion

/* File: tb/lsc_monitor.sv */
/* Port checker for lsc_conversion. Assumes a bind from the bench top. */
`timescale 1ns/1ps
module lsc_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic [6:0] bus_target,
	input wire lsc_pkg::lsc_access_s access,
	input wire logic osc_tick,
	input wire logic photo_pulse,
	input wire logic [7:0] read_data,
	input wire logic read_valid,
	input wire logic [7:0] command_out,
	input wire logic conversion_done,
	input wire logic powered_up,
	input wire logic counter_overflow
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Relations between requests, answers and status outputs
	a_read_answered: assert property (access.rd && bus_target == 7'h44 |=> read_valid)
		else $error("read lost");
	a_no_stray_valid: assert property (!(access.rd && bus_target == 7'h44) |=> !read_valid)
		else $error("stray valid");
	a_cmd_write_taken: assert property (access.wr && bus_target == 7'h44 && access.addr == 8'h00
		|=> command_out == $past(access.wdata)) else $error("command lost");
	a_unmapped_zero: assert property (access.rd && bus_target == 7'h44 && access.addr == 8'h03
		|=> read_data == 8'h00) else $error("unmapped read");
	a_reset_clear: assert property ($past(reset) |-> command_out == 8'h00 && !powered_up)
		else $error("reset state");
	a_done_pulse: assert property (conversion_done |=> !conversion_done)
		else $error("done too long");
	a_done_cause: assert property (conversion_done |-> $past(osc_tick) || $past(access.wr)
		|| $past(osc_tick, 2) || $past(access.wr, 2)) else $error("done uncaused");
	a_oneshot_off: assert property (conversion_done && !command_out[6] |-> ##[0:1] !powered_up)
		else $error("still powered");
endmodule : lsc_monitor

/* File: tb/lsc_host.sv */
/* Host controller model. Assumes decoded accesses, driven at the falling edge. */
`timescale 1ns/1ps
module lsc_host (
	input wire logic clk,
	input wire logic [7:0] read_data,
	output lsc_pkg::lsc_access_s access,
	output logic [6:0] bus_target
);
	// Idle bus at time zero
	initial access = '0;
	initial bus_target = 7'h44;
	// One write pulse; the idle bus then carries scrambled values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		access = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		access = '{1'b0, 1'b0, ~a, ~d};
	endtask : wr
	// One read pulse; data taken in the answer cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(negedge clk);
		access = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		access = '{1'b0, 1'b0, ~a, 8'hA5};
		q = read_data;
	endtask : rd
endmodule : lsc_host

/* File: tb/light_sensor_conversion_timing_tb_top.sv */
/* Top bench with random light pulses. Assumes the host model and checker. */
`timescale 1ns/1ps
module light_sensor_conversion_timing_tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic osc_tick = 1'b0;
	logic photo_pulse = 1'b0;
	logic [6:0] bus_target;
	lsc_pkg::lsc_access_s access;
	logic [7:0] read_data;
	logic [7:0] command_out;
	logic read_valid;
	logic conversion_done;
	logic powered_up;
	logic counter_overflow;
	logic [7:0] cmds [4] = '{8'hCC, 8'hC8, 8'hC4, 8'h8C};
	logic [15:0] n;
	logic [15:0] r;
	logic [15:0] r2;
	integer seed = 5104;
	integer failures = 0;
	integer compares = 0;
	int k;
	// Clock
	always #2.5 clk = ~clk;
	lsc_conversion dut_u (
		.clk(clk),
		.reset(reset),
		.bus_target(bus_target),
		.access(access),
		.osc_tick(osc_tick),
		.photo_pulse(photo_pulse),
		.read_data(read_data),
		.read_valid(read_valid),
		.command_out(command_out),
		.conversion_done(conversion_done),
		.powered_up(powered_up),
		.counter_overflow(counter_overflow)
	);
	lsc_host host_u (.clk(clk), .read_data(read_data), .access(access), .bus_target(bus_target));
	// Count and report one comparison
	task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic test_done;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	// Result word from its two bytes
	task automatic result(output logic [15:0] v);
		host_u.rd(8'h02, v[15:8]);
		host_u.rd(8'h01, v[7:0]);
	endtask : result
	// Ticks with random pulses between them; the sum is the expected count
	task automatic feed(input int c, output logic [15:0] p);
		p = '0;
		for (int i = 0; i < c; i++)
		begin
			@(negedge clk);
			osc_tick = 1'b1;
			photo_pulse = 1'b0;
			@(negedge clk);
			osc_tick = 1'b0;
			photo_pulse = (i < c - 1) ? 1'($random(seed)) : 1'b0;
			p = p + 16'(photo_pulse);
		end
	endtask : feed
	// Bounded wait for the end of a conversion
	task automatic wait_done;
		for (int i = 0; i < 20 && conversion_done !== 1'b1; i++)
			@(negedge clk);
		check("done", 16'h0001, 16'(conversion_done));
	endtask : wait_done
	// Ticks per internal window from the resolution bits
	function automatic int span(input logic [7:0] c);
		return 1 << (16 - 4 * int'(c[3:2]));
	endfunction : span
	// Main sequence
	initial
	begin
		repeat (6) @(negedge clk);
		reset = 1'b0;
		result(r);
		check("reset", 16'h0000, r);
		for (int j = 0; j < 4; j++)
		begin
			host_u.wr(8'h00, cmds[j]);
			feed(span(cmds[j]), n);
			wait_done;
			result(r);
			check("adc", n, r);
			check("power", 16'(cmds[j][6]), 16'(powered_up));
		end
		host_u.wr(8'h01, 8'($random(seed)));
		host_u.wr(8'h02, 8'($random(seed)));
		result(r2);
		check("readonly", r, r2);
		host_u.rd(8'h03, r2[7:0]);
		check("unmapped", 16'h0000, {8'h00, r2[7:0]});
		host_u.wr(8'h00, 8'hD4);
		host_u.wr(8'h80, 8'h00);
		// Window of whole sixteen-tick noise periods
		k = 16 * (1 + ($random(seed) & 7));
		feed(k, n);
		host_u.wr(8'h80, 8'h00);
		wait_done;
		result(r);
		check("timer", 16'(k), r);
		check("overflow", 16'h0000, 16'(counter_overflow));
		host_u.wr(8'h00, 8'hD0);
		result(r);
		check("adc after timer", n, r);
		test_done;
	end
	// Watchdog, about a third above the expected run
	initial
	begin
		#60000;
		failures++;
		test_done;
	end
endmodule : light_sensor_conversion_timing_tb_top
bind lsc_conversion lsc_monitor mon_u (
	.clk(clk),
	.reset(reset),
	.bus_target(bus_target),
	.access(access),
	.osc_tick(osc_tick),
	.photo_pulse(photo_pulse),
	.read_data(read_data),
	.read_valid(read_valid),
	.command_out(command_out),
	.conversion_done(conversion_done),
	.powered_up(powered_up),
	.counter_overflow(counter_overflow)
);
